// ==== inc/asdt_pkg.sv ====
// package: constants, enums and structs of the audio serial decoder and trigger
package asdt_pkg;

  // ************************************************************
  // widths and field sizes
  // ************************************************************
  localparam int WORD_W = 32;
  localparam int LEN_W = 6;
  localparam int SLOT_W = 4;
  localparam int CNT_W = 16;
  localparam int POS_W = 10;
  localparam logic [LEN_W-1:0] MAX_LEN = 6'h20;
  localparam logic [SLOT_W-1:0] MAX_SLOTS = 4'h8;

  // ************************************************************
  // reset values of the configuration
  // ************************************************************
  localparam logic [LEN_W-1:0] RST_SLOT_BITS = 6'h08;
  localparam logic [LEN_W-1:0] RST_WORD_SKIP = 6'h01;
  localparam logic [SLOT_W-1:0] RST_SLOT_COUNT = 4'h8;
  localparam logic [LEN_W-1:0] RST_FRAME_DELAY = 6'h00;
  localparam logic [LEN_W-1:0] RST_WORD_BITS = 6'h08;

  // ************************************************************
  // enumerations
  // ************************************************************
  typedef enum logic [1:0] {
    FMT_STANDARD = 2'h0,
    FMT_LEFT_JUST = 2'h1,
    FMT_RIGHT_JUST = 2'h2,
    FMT_TDM = 2'h3
  } asdt_format_e;

  typedef enum logic [2:0] {
    CMP_OFF = 3'h0,
    CMP_EQUAL = 3'h1,
    CMP_NOT_EQUAL = 3'h2,
    CMP_GREATER = 3'h3,
    CMP_LESS = 3'h4,
    CMP_INSIDE = 3'h5,
    CMP_OUTSIDE = 3'h6
  } asdt_cmp_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DELAY = 3'b010,
    ST_SLOTS = 3'b100
  } asdt_state_e;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    asdt_format_e formatVariant;
    logic [LEN_W-1:0] slotBits;
    logic [LEN_W-1:0] wordSkip;
    logic [SLOT_W-1:0] slotCount;
    logic [LEN_W-1:0] frameStartDelay;
    logic [LEN_W-1:0] audioWordBits;
    logic rightChannelFirst;
    logic sampleOnFalling;
    logic lowMeansOne;
    logic wordSelectInvert;
    logic lowBitLeading;
  } asdt_cfg_s;

  typedef struct packed {
    asdt_cmp_e op;
    logic signed [WORD_W-1:0] lowerReferenceValue;
    logic signed [WORD_W-1:0] upperReferenceValue;
  } asdt_cond_s;

  typedef struct packed {
    logic signed [WORD_W-1:0] leftWord;
    logic signed [WORD_W-1:0] rightWord;
    logic wordsValid;
    logic [CNT_W-1:0] decodedFrameTotal;
    logic frameLengthMismatch;
    logic trigger;
  } asdt_out_s;

endpackage

// ==== rtl/asdt_sync_edge.sv ====
// three-line synchroniser with edge detection for bit clock and word select
module asdt_sync_edge
  import asdt_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // raw lines
  input wire logic [2:0] lineIn,
  // synchronised lines and edges
  output logic [2:0] lineSync,
  output logic [2:0] lineRise,
  output logic [2:0] lineFall
);

  typedef struct packed {
    logic [2:0] stage1;
    logic [2:0] stage2;
    logic [2:0] stage3;
    logic [2:0] warm;
  } asdt_sync_s;

  asdt_sync_s state_reg;
  asdt_sync_s state_next;

  // ************************************************************
  // two flops per line, third flop for edges
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    state_next.stage1 = lineIn;
    state_next.stage2 = state_reg.stage1;
    state_next.stage3 = state_reg.stage2;
    state_next.warm = {state_reg.warm[1:0], 1'b1};
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign lineSync = state_reg.stage2;
  // no edges until the third flop holds a sampled level, so reset makes none
  assign lineRise = state_reg.stage2 & ~state_reg.stage3 & {3{state_reg.warm[2]}};
  assign lineFall = ~state_reg.stage2 & state_reg.stage3 & {3{state_reg.warm[2]}};

endmodule

// ==== rtl/asdt_decode_trigger.sv ====
// audio serial receive decoder with data and frame-length trigger
// Behaviour
// - tdm slot length is slotBits bit clocks, default 8
// - tdm and left-justified skip wordSkip bits before the word, default 1
// - non-tdm channel order picks left or right first, default left
// - tdm frame holds slotCount slots, default 8
// - data sampled on rising or falling bit clock edge, default rising
// - data polarity high-means-one or inverts every sampled bit
// - tdm slots and the first non-tdm channel delayed frameStartDelay bits after frame start, default 0
// - audio words are 1 to slot-length bits, default 8
// - non-tdm word select low is left, inverted swaps it
// - tdm frame starts on sync rising edge, or falling when inverted
// - count of decoded frames kept readable
// - per channel operator off, eq, ne, gt, lt, inside, outside
// - single-value operators compare against the lower reference value
// - range operators use lower and upper reference bounds
// - words and references are signed, sized by word length
// - format selects standard, left-justified, right-justified or tdm
// - bit order msb first by default, or lsb first
// - combined and/or condition must hold within one frame
// - flag consecutive frames of differing length, trigger next edge
module asdt_decode_trigger
  import asdt_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // audio bus pins
  input wire logic bitClock,
  input wire logic wordSelect,
  input wire logic serialData,
  // configuration
  input wire asdt_pkg::asdt_cfg_s cfg,
  input wire asdt_pkg::asdt_cond_s leftCond,
  input wire asdt_pkg::asdt_cond_s rightCond,
  input wire logic combineWithOr,
  // results
  output asdt_pkg::asdt_out_s result
);
  import asdt_pkg::*;

  typedef struct packed {
    asdt_state_e fsm;
    logic [LEN_W-1:0] delayCnt;
    logic [LEN_W-1:0] bitInSlot;
    logic [SLOT_W-1:0] slotIdx;
    logic [POS_W-1:0] frameBits;
    logic [POS_W-1:0] lastFrameBits;
    logic haveLast;
    logic frameOpen;
    logic [WORD_W-1:0] shiftWord;
    logic [LEN_W-1:0] wordPos;
    logic signed [WORD_W-1:0] leftWord;
    logic signed [WORD_W-1:0] rightWord;
    logic gotLeft;
    logic gotRight;
    logic leftHit;
    logic rightHit;
    logic mismatchPend;
    asdt_out_s out;
  } asdt_state_s;

  asdt_state_s state_reg;
  asdt_state_s state_next;
  logic [2:0] lineSync;
  logic [2:0] lineRise;
  logic [2:0] lineFall;

  asdt_sync_edge syncEdge (
    .sys_clk(sys_clk),
    .reset(reset),
    .lineIn({serialData, wordSelect, bitClock}),
    .lineSync(lineSync),
    .lineRise(lineRise),
    .lineFall(lineFall)
  );

  // ************************************************************
  // edge selection and per-format geometry
  // ************************************************************
  logic sampleEdge;
  logic frameEdge;
  logic dataBit;
  logic isTdm;
  logic [LEN_W-1:0] slotLen;
  logic [SLOT_W-1:0] slotsPerFrame;
  logic [LEN_W-1:0] skipBits;
  logic wsEdge;
  logic wsFrameEdge;

  always_comb
  begin
    isTdm = (cfg.formatVariant == FMT_TDM);
    sampleEdge = cfg.sampleOnFalling ? lineFall[0] : lineRise[0];
    dataBit = lineSync[2] ^ cfg.lowMeansOne;
    wsEdge = lineRise[1] | lineFall[1];
    // non-tdm frame begins at the edge into the first channel's level
    wsFrameEdge = (cfg.wordSelectInvert ^ cfg.rightChannelFirst) ? lineRise[1] : lineFall[1];
    if (isTdm)
    begin
      frameEdge = cfg.wordSelectInvert ? lineFall[1] : lineRise[1];
      slotLen = cfg.slotBits;
      slotsPerFrame = cfg.slotCount;
    end
    else
    begin
      frameEdge = wsFrameEdge;
      slotLen = MAX_LEN;
      slotsPerFrame = 4'h2;
    end
    if (isTdm || cfg.formatVariant == FMT_LEFT_JUST)
    begin
      skipBits = cfg.wordSkip;
    end
    else if (cfg.formatVariant == FMT_STANDARD)
    begin
      skipBits = 6'h01;
    end
    else
    begin
      skipBits = '0;
    end
  end

  // ************************************************************
  // signed compare of one channel
  // ************************************************************
  function automatic logic condHit(input asdt_cond_s c, input logic signed [WORD_W-1:0] w);
    logic hit;
    hit = 1'b0;
    case (c.op)
      CMP_EQUAL: hit = (w == c.lowerReferenceValue);
      CMP_NOT_EQUAL: hit = (w != c.lowerReferenceValue);
      CMP_GREATER: hit = (w > c.lowerReferenceValue);
      CMP_LESS: hit = (w < c.lowerReferenceValue);
      CMP_INSIDE: hit = (w >= c.lowerReferenceValue) && (w <= c.upperReferenceValue);
      CMP_OUTSIDE: hit = (w < c.lowerReferenceValue) || (w > c.upperReferenceValue);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // sign-extend a word of n bits, msb-first or lsb-first assembled
  function automatic logic signed [WORD_W-1:0] signWord(input logic [WORD_W-1:0] raw,
                                                         input logic [LEN_W-1:0] n);
    logic [WORD_W-1:0] v;
    v = raw;
    for (int i = 0; i < WORD_W; i++)
    begin
      if (i >= n)
      begin
        v[i] = raw[n-1];
      end
    end
    return v;
  endfunction

  // ************************************************************
  // frame decode state machine
  // ************************************************************
  logic [LEN_W-1:0] wordLen;
  logic [LEN_W-1:0] wordStart;
  logic inWord;
  logic slotEnd;
  logic [WORD_W-1:0] fullWord;
  logic signed [WORD_W-1:0] sWord;
  logic isLeftSlot;
  logic leftOn;
  logic rightOn;
  logic lHit;
  logic rHit;
  logic frameHit;

  always_comb
  begin
    state_next = state_reg;
    state_next.out.trigger = 1'b0;
    state_next.out.wordsValid = 1'b0;
    wordLen = (cfg.audioWordBits == '0) ? 6'h01 : cfg.audioWordBits;
    if (isTdm && wordLen > slotLen)
    begin
      wordLen = slotLen;
    end
    // right-justified words start at the slot start, i.e. at word-select edge, with no skip
    wordStart = skipBits;
    inWord = 1'b0;
    slotEnd = 1'b0;
    fullWord = state_reg.shiftWord;
    sWord = '0;
    isLeftSlot = (state_reg.slotIdx == '0) ^ (cfg.rightChannelFirst && !isTdm);
    leftOn = (leftCond.op != CMP_OFF);
    rightOn = (rightCond.op != CMP_OFF);
    lHit = 1'b0;
    rHit = 1'b0;
    frameHit = 1'b0;
    if (sampleEdge)
    begin
      state_next.frameBits = state_reg.frameBits + 10'h001;
    end
    case (state_reg.fsm)
      ST_IDLE:
      begin
        // frame length keeps counting up to the next frame edge
      end
      ST_DELAY:
      begin
        if (sampleEdge)
        begin
          state_next.delayCnt = state_reg.delayCnt + 6'h01;
          if (state_reg.delayCnt + 6'h01 >= cfg.frameStartDelay)
          begin
            state_next.fsm = ST_SLOTS;
          end
        end
      end
      ST_SLOTS:
      begin
        if (sampleEdge)
        begin
          inWord = (state_reg.bitInSlot >= wordStart) && (state_reg.wordPos < wordLen);
          if (inWord)
          begin
            if (cfg.lowBitLeading)
            begin
              fullWord = state_reg.shiftWord;
              fullWord[state_reg.wordPos[4:0]] = dataBit;
            end
            else
            begin
              fullWord = {state_reg.shiftWord[WORD_W-2:0], dataBit};
            end
            state_next.shiftWord = fullWord;
            state_next.wordPos = state_reg.wordPos + 6'h01;
            if (state_reg.wordPos + 6'h01 == wordLen)
            begin
              sWord = signWord(fullWord, wordLen);
              if (isLeftSlot)
              begin
                state_next.leftWord = sWord;
                state_next.gotLeft = 1'b1;
                state_next.leftHit = condHit(leftCond, sWord);
              end
              else if (state_reg.slotIdx < 4'h2)
              begin
                state_next.rightWord = sWord;
                state_next.gotRight = 1'b1;
                state_next.rightHit = condHit(rightCond, sWord);
              end
            end
          end
          slotEnd = isTdm && (state_reg.bitInSlot + 6'h01 >= slotLen);
          state_next.bitInSlot = slotEnd ? 6'h00 : state_reg.bitInSlot + 6'h01;
          if (slotEnd)
          begin
            state_next.wordPos = '0;
            state_next.shiftWord = '0;
            state_next.slotIdx = state_reg.slotIdx + 4'h1;
            if (state_reg.slotIdx + 4'h1 >= slotsPerFrame)
            begin
              state_next.fsm = ST_IDLE;
            end
          end
        end
      end
      default:
      begin
        state_next.fsm = ST_IDLE;
      end
    endcase
    // non-tdm channel change at a word-select edge other than the frame edge, outside idle
    if (!isTdm && wsEdge && !frameEdge && state_reg.fsm != ST_IDLE)
    begin
      state_next.slotIdx = 4'h1;
      state_next.bitInSlot = '0;
      state_next.wordPos = '0;
      state_next.shiftWord = '0;
    end
    // ************************************************************
    // frame boundary: close old frame, open new one
    // ************************************************************
    if (frameEdge)
    begin
      lHit = state_reg.gotLeft && state_reg.leftHit;
      rHit = state_reg.gotRight && state_reg.rightHit;
      if (combineWithOr)
      begin
        frameHit = (leftOn && lHit) || (rightOn && rHit);
      end
      else
      begin
        frameHit = (leftOn || rightOn) && (!leftOn || lHit) && (!rightOn || rHit);
      end
      if (state_reg.gotLeft || state_reg.gotRight)
      begin
        state_next.out.decodedFrameTotal = state_reg.out.decodedFrameTotal + 16'h0001;
        state_next.out.leftWord = state_reg.leftWord;
        state_next.out.rightWord = state_reg.rightWord;
        state_next.out.wordsValid = 1'b1;
      end
      if (state_reg.haveLast && state_reg.frameBits != state_reg.lastFrameBits)
      begin
        state_next.out.frameLengthMismatch = 1'b1;
        state_next.mismatchPend = 1'b1;
      end
      else
      begin
        state_next.out.frameLengthMismatch = 1'b0;
      end
      state_next.haveLast = state_reg.frameOpen;
      state_next.frameOpen = 1'b1;
      state_next.lastFrameBits = state_reg.frameBits;
      state_next.out.trigger = frameHit;
      state_next.fsm = (cfg.frameStartDelay == '0) ? ST_SLOTS : ST_DELAY;
      state_next.delayCnt = '0;
      state_next.bitInSlot = '0;
      state_next.slotIdx = '0;
      state_next.wordPos = '0;
      state_next.shiftWord = '0;
      state_next.frameBits = '0;
      state_next.gotLeft = 1'b0;
      state_next.gotRight = 1'b0;
      state_next.leftHit = 1'b0;
      state_next.rightHit = 1'b0;
    end
    else if (state_reg.mismatchPend && sampleEdge)
    begin
      state_next.mismatchPend = 1'b0;
      state_next.out.trigger = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg <= '0;
      state_reg.fsm <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign result = state_reg.out;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_mismatch_flag;
    state_reg.mismatchPend && !frameEdge && sampleEdge;
  endsequence

  a_trigger_one_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    result.trigger |=> !result.trigger || $past(frameEdge) || $past(sampleEdge))
    else $error("trigger held longer than allowed");
  a_mismatch_trigger: assert property (@(posedge sys_clk) disable iff (reset)
    s_mismatch_flag |=> result.trigger)
    else $error("no trigger after length mismatch");
  a_frame_count_step: assert property (@(posedge sys_clk) disable iff (reset)
    !frameEdge |=> $stable(result.decodedFrameTotal))
    else $error("frame count moved without frame edge");
  a_tdm_start_edge: assert property (@(posedge sys_clk) disable iff (reset)
    (isTdm && !cfg.wordSelectInvert && lineFall[1]) |=> !result.wordsValid)
    else $error("tdm frame started on wrong edge");
  a_delay_hold: assert property (@(posedge sys_clk) disable iff (reset)
    (state_reg.fsm == ST_DELAY) |-> state_reg.wordPos == '0)
    else $error("bits taken during frame delay");
  a_slot_bound: assert property (@(posedge sys_clk) disable iff (reset)
    (isTdm && state_reg.fsm == ST_SLOTS) |-> state_reg.slotIdx < MAX_SLOTS)
    else $error("slot index beyond frame");
  a_word_bound: assert property (@(posedge sys_clk) disable iff (reset)
    state_reg.wordPos <= MAX_LEN)
    else $error("word longer than allowed");
  a_off_no_hit: assert property (@(posedge sys_clk) disable iff (reset)
    (frameEdge && leftCond.op == CMP_OFF && rightCond.op == CMP_OFF) |=> !result.trigger)
    else $error("trigger with all operators off");

endmodule

// ==== bench/asdt_audio_tx.sv ====
// audio transmitter model driving bit clock, word select and data
module asdt_audio_tx
(
  // format to transmit
  input asdt_pkg::asdt_cfg_s txCfg,
  // audio bus pins
  output logic bitClock,
  output logic wordSelect,
  output logic serialData
);
  timeunit 1ns;
  timeprecision 1ns;
  import asdt_pkg::*;
  // level opening the first channel, or sync pulse level, read live
  function automatic logic first_level();
    return (txCfg.formatVariant == FMT_TDM) ? !txCfg.wordSelectInvert
      : (txCfg.rightChannelFirst ^ txCfg.wordSelectInvert);
  endfunction
  initial
  begin
    bitClock = 1'b1;
    wordSelect = 1'b0;
    serialData = 1'b0;
  end
  // clock stands at its post-sampling level between frames
  task automatic idle();
    bitClock = !txCfg.sampleOnFalling;
    wordSelect = !first_level();
    serialData = 1'b0;
  endtask
  // lines change on the non-sampling edge, one bit per 800 ns
  task automatic bit_out(input logic ws, input logic d);
    bitClock = txCfg.sampleOnFalling;
    wordSelect = ws;
    serialData = d;
    #400;
    bitClock = !txCfg.sampleOnFalling;
    #400;
  endtask
  task automatic send_frame(input logic [WORD_W-1:0] leftVal, input logic [WORD_W-1:0] rightVal);
    int slots, sb, skip, dly, wl, k, pos;
    logic tdm, sw, ws, d, fl;
    logic [WORD_W-1:0] w;
    tdm = txCfg.formatVariant == FMT_TDM;
    fl = first_level();
    slots = tdm ? int'(txCfg.slotCount) : 2;
    sb = int'(txCfg.slotBits);
    dly = int'(txCfg.frameStartDelay);
    wl = int'(txCfg.audioWordBits);
    skip = (txCfg.formatVariant == FMT_STANDARD) ? 1
      : (txCfg.formatVariant == FMT_RIGHT_JUST) ? 0 : int'(txCfg.wordSkip);
    sw = !tdm && txCfg.rightChannelFirst;
    d = serialData;
    for (int p = 0; p < slots * sb; p++)
    begin
      ws = tdm ? ((p == 0) ? fl : !fl) : ((p < sb) ? fl : !fl);
      k = (p - dly) / sb;
      pos = (p - dly) % sb - skip;
      if (p >= dly && k < 2 && pos >= 0 && pos < wl)
      begin
        w = ((k == 0) != sw) ? leftVal : rightVal;
        d = w[txCfg.lowBitLeading ? pos : wl - 1 - pos] ^ txCfg.lowMeansOne;
      end
      else
      begin
        d = !d;
      end
      bit_out(ws, d);
    end
  endtask
  // closing frame edge with one bit clock
  task automatic close();
    bit_out(first_level(), !serialData);
  endtask
endmodule

// ==== bench/asdt_decode_trigger_tb.sv ====
// self-checking testbench of the audio serial decoder and trigger
module asdt_decode_trigger_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import asdt_pkg::*;
  logic sys_clk, reset, bitClock, wordSelect, serialData, combineWithOr;
  asdt_cfg_s cfg, txCfg;
  asdt_cond_s leftCond, rightCond;
  asdt_out_s result;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] trigCount;
  logic [7:0] validCount;
  asdt_decode_trigger DUT (.sys_clk(sys_clk), .reset(reset), .bitClock(bitClock),
    .wordSelect(wordSelect), .serialData(serialData), .cfg(cfg), .leftCond(leftCond),
    .rightCond(rightCond), .combineWithOr(combineWithOr), .result(result));
  asdt_audio_tx tx (.txCfg(txCfg), .bitClock(bitClock), .wordSelect(wordSelect),
    .serialData(serialData));
  // ****************
  // clock, timeout, trigger counter
  // ****************
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = !sys_clk;
  end
  always @(posedge sys_clk)
  begin
    trigCount <= reset ? 8'h00 : trigCount + 8'(result.trigger === 1'b1);
    validCount <= reset ? 8'h00 : validCount + 8'(result.wordsValid === 1'b1);
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      end_of_test();
    end
  end
  // ****************
  // helpers
  // ****************
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [WORD_W-1:0] seen,
    input logic [WORD_W-1:0] want);
    checked++;
    if (seen !== want)
    begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, want, seen);
    end
  endtask
  function automatic asdt_cfg_s defaults();
    asdt_cfg_s c;
    c = '0;
    c.formatVariant = FMT_STANDARD;
    c.slotBits = RST_SLOT_BITS;
    c.wordSkip = RST_WORD_SKIP;
    c.slotCount = RST_SLOT_COUNT;
    c.frameStartDelay = RST_FRAME_DELAY;
    c.audioWordBits = RST_WORD_BITS;
    return c;
  endfunction
  function automatic asdt_cond_s cond(input asdt_cmp_e op, input int lo, input int hi);
    asdt_cond_s c;
    c.op = op;
    c.lowerReferenceValue = lo;
    c.upperReferenceValue = hi;
    return c;
  endfunction
  function automatic logic hit(input asdt_cond_s c, input logic [WORD_W-1:0] v);
    logic signed [WORD_W-1:0] s, lo, hi;
    s = $signed(v);
    lo = $signed(c.lowerReferenceValue);
    hi = $signed(c.upperReferenceValue);
    case (c.op)
      CMP_EQUAL: return s == lo;
      CMP_NOT_EQUAL: return s != lo;
      CMP_GREATER: return s > lo;
      CMP_LESS: return s < lo;
      CMP_INSIDE: return s >= lo && s <= hi;
      CMP_OUTSIDE: return s < lo || s > hi;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [WORD_W-1:0] sext(input logic [WORD_W-1:0] v, input logic [LEN_W-1:0] wl);
    logic [WORD_W-1:0] x;
    x = v << (WORD_W - int'(wl));
    return WORD_W'($signed(x) >>> (WORD_W - int'(wl)));
  endfunction
  task automatic start(input asdt_cfg_s c);
    @(posedge sys_clk);
    #1;
    reset = 1'b1;
    cfg = c;
    txCfg = c;
    tx.idle();
    repeat (6) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // two equal frames, then words, count and trigger pulses judged
  task automatic run_case(input asdt_cfg_s c, input logic [WORD_W-1:0] l, input logic [WORD_W-1:0] r);
    logic [WORD_W-1:0] el, er;
    logic onL, onR, fire;
    el = sext(l, c.audioWordBits);
    er = sext(r, c.audioWordBits);
    onL = leftCond.op != CMP_OFF;
    onR = rightCond.op != CMP_OFF;
    fire = combineWithOr ? (onL && hit(leftCond, el)) || (onR && hit(rightCond, er))
      : (onL || onR) && (!onL || hit(leftCond, el)) && (!onR || hit(rightCond, er));
    start(c);
    tx.send_frame(l, r);
    tx.send_frame(l, r);
    tx.close();
    repeat (10) @(posedge sys_clk);
    #1;
    check("leftWord", result.leftWord, el);
    check("rightWord", result.rightWord, er);
    check("frameTotal", WORD_W'(result.decodedFrameTotal), 32'h0000_0002);
    check("mismatch", WORD_W'(result.frameLengthMismatch), 32'h0000_0000);
    check("triggers", WORD_W'(trigCount), fire ? 32'h0000_0002 : 32'h0000_0000);
    check("validPulses", WORD_W'(validCount), 32'h0000_0002);
  endtask
  // ****************
  // scenarios
  // ****************
  // outside tdm slotBits only sets the transmitter's channel length
  task automatic s_standard();
    asdt_cfg_s c;
    c = defaults();
    c.slotBits = 6'h10;
    rightCond = cond(CMP_OFF, 0, 0);
    combineWithOr = 1'b0;
    leftCond = cond(CMP_EQUAL, 90, 0);
    run_case(c, 32'h0000_005A, 32'h0000_00A5);
    leftCond = cond(CMP_EQUAL, 91, 0);
    run_case(c, 32'h0000_005A, 32'h0000_00A5);
  endtask
  task automatic s_left_just();
    asdt_cfg_s c;
    c = defaults();
    c.formatVariant = FMT_LEFT_JUST;
    c.wordSkip = 6'h02;
    c.slotBits = 6'h10;
    c.rightChannelFirst = 1'b1;
    c.lowBitLeading = 1'b1;
    leftCond = cond(CMP_GREATER, -10, 0);
    rightCond = cond(CMP_LESS, 0, 0);
    combineWithOr = 1'b0;
    run_case(c, 32'h0000_005A, 32'h0000_00A5);
  endtask
  task automatic s_right_just();
    asdt_cfg_s c;
    c = defaults();
    c.formatVariant = FMT_RIGHT_JUST;
    c.lowMeansOne = 1'b1;
    c.sampleOnFalling = 1'b1;
    c.wordSelectInvert = 1'b1;
    c.audioWordBits = 6'h06;
    leftCond = cond(CMP_INSIDE, -30, -20);
    rightCond = cond(CMP_NOT_EQUAL, 26, 0);
    combineWithOr = 1'b1;
    run_case(c, 32'h0000_0025, 32'h0000_001A);
  endtask
  task automatic s_tdm();
    asdt_cfg_s c;
    c = defaults();
    c.formatVariant = FMT_TDM;
    c.slotCount = 4'h4;
    c.slotBits = 6'h06;
    c.wordSkip = 6'h00;
    c.frameStartDelay = 6'h02;
    c.audioWordBits = 6'h04;
    leftCond = cond(CMP_OUTSIDE, -6, 6);
    rightCond = cond(CMP_EQUAL, -7, 0);
    combineWithOr = 1'b0;
    run_case(c, 32'h0000_0007, 32'h0000_0009);
  endtask
  task automatic s_tdm_invert();
    asdt_cfg_s c;
    c = defaults();
    c.formatVariant = FMT_TDM;
    c.wordSelectInvert = 1'b1;
    c.wordSkip = 6'h00;
    leftCond = cond(CMP_LESS, -127, 0);
    rightCond = cond(CMP_GREATER, 126, 0);
    combineWithOr = 1'b0;
    run_case(c, 32'h0000_0080, 32'h0000_007F);
  endtask
  // second frame shorter than the first
  task automatic s_mismatch();
    asdt_cfg_s c;
    c = defaults();
    c.audioWordBits = 6'h04;
    leftCond = cond(CMP_OFF, 0, 0);
    rightCond = cond(CMP_OFF, 0, 0);
    start(c);
    tx.send_frame(32'h0000_0003, 32'h0000_0005);
    txCfg.slotBits = 6'h06;
    tx.send_frame(32'h0000_0003, 32'h0000_0005);
    tx.close();
    repeat (12) @(posedge sys_clk);
    #1;
    check("mismatch", WORD_W'(result.frameLengthMismatch), 32'h0000_0001);
    check("triggers", WORD_W'(trigCount), 32'h0000_0001);
    check("rightWord", result.rightWord, 32'h0000_0005);
  endtask
  initial
  begin
    reset = 1'b1;
    cfg = defaults();
    txCfg = defaults();
    leftCond = '0;
    rightCond = '0;
    combineWithOr = 1'b0;
    s_standard();
    s_left_just();
    s_right_just();
    s_tdm();
    s_tdm_invert();
    s_mismatch();
    end_of_test();
  end
endmodule
